// ---- hdl/omd_diag_regs.sv ----
// diagnostic and status byte bank behind a two-wire serial management slave
//
// Overview of operation
// - bias current pair at 0x64/0x65
// - transmit power pair at 0x66/0x67
// - receive power pair at 0x68/0x69
// - two auxiliary pairs at 0x6A..0x6D
// - not-ready flag high until first sample
// - signal-lost level in bit 1, prompt update
// - interrupt pin level in bit 2
// - soft power-down bit enters low-power mode
// - soft power-down never causes module reset
// - power-down pin level in bit 4
// - not-ready pin level in bit 5
// - writing one to bit 6 disables laser
// - laser follows write within 100 ms
// - laser off is soft OR pin disable
// - soft laser disable resets to zero
// - transmit-disable pin level in bit 7
// - lock byte bits 0-2 read zero
// - receive recovery unlock in lock bit 3
`timescale 1ns/100ps
`default_nettype none
module omd_diag_regs
	import omd_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic mgmtScl,
	input wire logic mgmtSdaIn,
	output logic mgmtSdaOut,
	output logic mgmtSdaOe,
	input wire logic [15:0] biasMeas,
	input wire logic [15:0] txPowerMeas,
	input wire logic [15:0] rxPowerMeas,
	input wire logic [15:0] auxOneMeas,
	input wire logic [15:0] auxTwoMeas,
	input wire logic measStrobe,
	input wire logic optical_signal_lost,
	input wire logic intPinLevel,
	input wire logic powerDownPin,
	input wire logic module_unready_pin,
	input wire logic txDisablePin,
	input wire logic receive_recovery_unlocked,
	output logic laserOff,
	output logic powerDownMode,
	output logic moduleReset
);

	typedef struct packed {
		omd_link_t link;
		logic sclPrev;
		logic sdaPrev;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic ptrSet;
		logic isRead;
		logic hostAck;
		logic sdaOe;
		logic [MEAS_COUNT-1:0][15:0] meas;
		logic holdValid;
		logic [7:0] holdAddr;
		logic [7:0] holdLow;
		logic dataNotReady;
		logic losLvl;
		logic intLvl;
		logic pdLvl;
		logic unreadyLvl;
		logic txDisLvl;
		logic unlockLvl;
		logic softPd;
		logic softTxDis;
		logic laserOff;
		logic powerDown;
		logic modReset;
	} omd_state_t;

	omd_state_t r;
	omd_state_t next_r;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic wrCtrl;
	logic loadHigh;
	logic [7:0] ctrlView, lockView;

	// pair index of a measurement offset
	function automatic logic [2:0] pairIndex(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - OFS_BIAS_HI;
		return rel[3:1];
	endfunction : pairIndex

	function automatic logic isMeasAddr(input logic [7:0] addr);
		return (addr >= OFS_BIAS_HI) && (addr <= OFS_AUX2_LO);
	endfunction : isMeasAddr

	// byte the host sees at an offset
	function automatic logic [7:0] readByte(input logic [7:0] addr, input omd_state_t s);
		logic [7:0] b;
		b = 8'h00;
		if (isMeasAddr(addr))
		begin
			if (s.holdValid && (addr == s.holdAddr))
				b = s.holdLow;
			else if (addr[0] == OFS_BIAS_HI[0])
				b = s.meas[pairIndex(addr)][15:8];
			else
				b = s.meas[pairIndex(addr)][7:0];
		end
		else if (addr == OFS_CTRL)
		begin
			b[BIT_DATA_NOT_READY] = s.dataNotReady;
			b[BIT_SIGNAL_LOST] = s.losLvl;
			b[BIT_INT_LEVEL] = s.intLvl;
			b[BIT_SOFT_PDOWN] = s.softPd;
			b[BIT_PDOWN_LEVEL] = s.pdLvl;
			b[BIT_UNREADY_LEVEL] = s.unreadyLvl;
			b[BIT_SOFT_TXDIS] = s.softTxDis;
			b[BIT_TXDIS_LEVEL] = s.txDisLvl;
		end
		else if (addr == OFS_LOCK)
		begin
			b[BIT_RX_UNLOCKED] = s.unlockLvl;
		end
		return b;
	endfunction : readByte

	always_comb
	begin
		next_r = r;
		wrCtrl = 1'b0;
		loadHigh = 1'b0;
		sclRise = mgmtScl && !r.sclPrev;
		sclFall = !mgmtScl && r.sclPrev;
		startSeen = mgmtScl && r.sclPrev && r.sdaPrev && !mgmtSdaIn;
		stopSeen = mgmtScl && r.sclPrev && !r.sdaPrev && mgmtSdaIn;
		next_r.sclPrev = mgmtScl;
		next_r.sdaPrev = mgmtSdaIn;

		// pin mirrors, refreshed every cycle
		next_r.losLvl = optical_signal_lost;
		next_r.intLvl = intPinLevel;
		next_r.pdLvl = powerDownPin;
		next_r.unreadyLvl = module_unready_pin;
		next_r.txDisLvl = txDisablePin;
		next_r.unlockLvl = receive_recovery_unlocked;

		if (measStrobe)
		begin
			next_r.meas[0] = biasMeas;
			next_r.meas[1] = txPowerMeas;
			next_r.meas[2] = rxPowerMeas;
			next_r.meas[3] = auxOneMeas;
			next_r.meas[4] = auxTwoMeas;
			next_r.dataNotReady = 1'b0;
		end

		if (startSeen)
		begin
			next_r.link = OMD_ADDR;
			next_r.bitCnt = 4'h0;
			next_r.sdaOe = 1'b0;
		end
		else if (stopSeen)
		begin
			next_r.link = OMD_IDLE;
			next_r.sdaOe = 1'b0;
		end
		else if (sclRise)
		begin
			case (r.link)
				OMD_ADDR, OMD_RX:
				begin
					next_r.shift = {r.shift[6:0], mgmtSdaIn};
					next_r.bitCnt = r.bitCnt + 4'h1;
				end
				OMD_ACK_TX:
				begin
					next_r.hostAck = !mgmtSdaIn;
				end
				default:
				begin
					next_r.hostAck = r.hostAck;
				end
			endcase
		end
		else if (sclFall)
		begin
			case (r.link)
				OMD_ADDR:
				begin
					if (r.bitCnt == BITS_PER_BYTE)
					begin
						if (r.shift[7:1] == DEV_ADDR)
						begin
							next_r.link = OMD_ACK_ADDR;
							next_r.isRead = r.shift[0];
							next_r.ptrSet = r.shift[0];
							next_r.sdaOe = 1'b1;
						end
						else
						begin
							next_r.link = OMD_IDLE;
						end
					end
				end
				OMD_ACK_ADDR, OMD_ACK_TX:
				begin
					if (r.link == OMD_ACK_TX && !r.hostAck)
					begin
						next_r.link = OMD_IDLE;
						next_r.sdaOe = 1'b0;
					end
					else if (r.isRead)
					begin
						next_r.shift = readByte(r.ptr, r);
						next_r.sdaOe = !next_r.shift[7];
						next_r.ptr = r.ptr + 8'h01;
						next_r.bitCnt = 4'h1;
						next_r.link = OMD_TX;
						if (isMeasAddr(r.ptr) && (r.ptr[0] == OFS_BIAS_HI[0]))
						begin
							loadHigh = 1'b1;
							next_r.holdValid = 1'b1;
							next_r.holdAddr = r.ptr + 8'h01;
							next_r.holdLow = r.meas[pairIndex(r.ptr)][7:0];
						end
					end
					else
					begin
						next_r.sdaOe = 1'b0;
						next_r.bitCnt = 4'h0;
						next_r.link = OMD_RX;
					end
				end
				OMD_RX:
				begin
					if (r.bitCnt == BITS_PER_BYTE)
					begin
						next_r.sdaOe = 1'b1;
						next_r.link = OMD_ACK_RX;
						if (!r.ptrSet)
						begin
							next_r.ptr = r.shift;
							next_r.ptrSet = 1'b1;
						end
						else
						begin
							if (r.ptr == OFS_CTRL)
							begin
								wrCtrl = 1'b1;
								next_r.softPd = r.shift[BIT_SOFT_PDOWN];
								next_r.softTxDis = r.shift[BIT_SOFT_TXDIS];
							end
							next_r.ptr = r.ptr + 8'h01;
						end
					end
				end
				OMD_ACK_RX:
				begin
					next_r.sdaOe = 1'b0;
					next_r.bitCnt = 4'h0;
					next_r.link = OMD_RX;
				end
				OMD_TX:
				begin
					if (r.bitCnt == BITS_PER_BYTE)
					begin
						next_r.sdaOe = 1'b0;
						next_r.link = OMD_ACK_TX;
					end
					else
					begin
						next_r.shift = {r.shift[6:0], 1'h0};
						next_r.sdaOe = !r.shift[6];
						next_r.bitCnt = r.bitCnt + 4'h1;
					end
				end
				default:
				begin
					next_r.link = OMD_IDLE;
				end
			endcase
		end

		// laser and power control, one cycle behind their causes
		next_r.laserOff = next_r.softTxDis | txDisablePin;
		next_r.powerDown = next_r.softPd | powerDownPin;
		next_r.modReset = r.pdLvl & ~powerDownPin;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			r <= '0;
			r.sclPrev <= 1'h1;
			r.sdaPrev <= 1'h1;
			r.dataNotReady <= 1'h1;
			r.softTxDis <= 1'h0;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign mgmtSdaOut = 1'h0;
	assign mgmtSdaOe = r.sdaOe;
	assign laserOff = r.laserOff;
	assign powerDownMode = r.powerDown;
	assign moduleReset = r.modReset;
	assign ctrlView = readByte(OFS_CTRL, r);
	assign lockView = readByte(OFS_LOCK, r);

	sequence s_firstSample;
		measStrobe && r.dataNotReady;
	endsequence

	sequence s_ctrlWrite;
		wrCtrl;
	endsequence

	property p_notready_clears;
		@(posedge core_clk) disable iff (!reset_n)
		s_firstSample |=> !r.dataNotReady;
	endproperty
	a_notready_clears: assert property (p_notready_clears) else $error("not-ready stuck");

	property p_notready_never_rises;
		@(posedge core_clk) disable iff (!reset_n)
		!$rose(r.dataNotReady);
	endproperty
	a_notready_never_rises: assert property (p_notready_never_rises) else $error("not-ready rose");

	property p_laser_or;
		@(posedge core_clk) disable iff (!reset_n)
		txDisablePin |=> laserOff;
	endproperty
	a_laser_or: assert property (p_laser_or) else $error("laser not off");

	property p_laser_soft;
		@(posedge core_clk) disable iff (!reset_n)
		(s_ctrlWrite ##0 r.shift[BIT_SOFT_TXDIS]) |=> laserOff;
	endproperty
	a_laser_soft: assert property (p_laser_soft) else $error("soft disable ignored");

	property p_laser_on;
		@(posedge core_clk) disable iff (!reset_n)
		(!txDisablePin && !r.softTxDis && !wrCtrl) |=> !laserOff;
	endproperty
	a_laser_on: assert property (p_laser_on) else $error("laser off without cause");

	property p_softtx_only_by_write;
		@(posedge core_clk) disable iff (!reset_n)
		$changed(r.softTxDis) |-> $past(wrCtrl);
	endproperty
	a_softtx_only_by_write: assert property (p_softtx_only_by_write) else $error("soft disable moved");

	property p_reset_only_pin;
		@(posedge core_clk) disable iff (!reset_n)
		moduleReset |-> $fell(r.pdLvl);
	endproperty
	a_reset_only_pin: assert property (p_reset_only_pin) else $error("reset without pin fall");

	property p_softpd_lowpower;
		@(posedge core_clk) disable iff (!reset_n)
		r.softPd |-> powerDownMode;
	endproperty
	a_softpd_lowpower: assert property (p_softpd_lowpower) else $error("soft power-down ignored");

	property p_txdis_mirror;
		@(posedge core_clk) disable iff (!reset_n)
		$changed(txDisablePin) |=> ctrlView[BIT_TXDIS_LEVEL] == $past(txDisablePin);
	endproperty
	a_txdis_mirror: assert property (p_txdis_mirror) else $error("disable level stale");

	property p_reserved_zero;
		@(posedge core_clk) disable iff (!reset_n)
		lockView[RESERVED_LOCK_BITS-1:0] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_hold_from_high_read;
		@(posedge core_clk) disable iff (!reset_n)
		$changed(r.holdLow) |-> $past(loadHigh);
	endproperty
	a_hold_from_high_read: assert property (p_hold_from_high_read) else $error("snapshot moved");

endmodule : omd_diag_regs
`default_nettype wire

// ---- include/omd_pkg.sv ----
// package: register map, field positions and protocol constants of the diagnostic byte block
package omd_pkg;
	localparam logic [7:0] OFS_BIAS_HI = 8'h64;
	localparam logic [7:0] OFS_BIAS_LO = 8'h65;
	localparam logic [7:0] OFS_TXPWR_HI = 8'h66;
	localparam logic [7:0] OFS_TXPWR_LO = 8'h67;
	localparam logic [7:0] OFS_RXPWR_HI = 8'h68;
	localparam logic [7:0] OFS_RXPWR_LO = 8'h69;
	localparam logic [7:0] OFS_AUX1_HI = 8'h6a;
	localparam logic [7:0] OFS_AUX1_LO = 8'h6b;
	localparam logic [7:0] OFS_AUX2_HI = 8'h6c;
	localparam logic [7:0] OFS_AUX2_LO = 8'h6d;
	localparam logic [7:0] OFS_CTRL = 8'h6e;
	localparam logic [7:0] OFS_LOCK = 8'h6f;
	localparam int MEAS_COUNT = 5;
	// control and status byte bit positions
	localparam int BIT_DATA_NOT_READY = 0;
	localparam int BIT_SIGNAL_LOST = 1;
	localparam int BIT_INT_LEVEL = 2;
	localparam int BIT_SOFT_PDOWN = 3;
	localparam int BIT_PDOWN_LEVEL = 4;
	localparam int BIT_UNREADY_LEVEL = 5;
	localparam int BIT_SOFT_TXDIS = 6;
	localparam int BIT_TXDIS_LEVEL = 7;
	// lock byte bit positions
	localparam int BIT_RX_UNLOCKED = 3;
	localparam int RESERVED_LOCK_BITS = 3;
	// serial link
	localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h50;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [2:0] {
		OMD_IDLE = 3'b000,
		OMD_ADDR = 3'b001,
		OMD_ACK_ADDR = 3'b010,
		OMD_RX = 3'b011,
		OMD_ACK_RX = 3'b100,
		OMD_TX = 3'b101,
		OMD_ACK_TX = 3'b110
	} omd_link_t;
endpackage : omd_pkg

// ---- dv/omd_host.sv ----
// two-wire host controller model for the management link
`timescale 1ns/100ps
`default_nettype none
module omd_host
(
	input wire logic core_clk,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaOe
);
	int half = 8;
	initial
	begin
		scl = 1'b1;
		sdaOe = 1'b0;
	end
	task automatic hold();
		repeat (half) @(negedge core_clk);
	endtask : hold
	task automatic bitx(input logic b, output logic r);
		sdaOe = ~b;
		hold();
		scl = 1'b1;
		hold();
		r = sdaLine;
		scl = 1'b0;
		hold();
	endtask : bitx
	task automatic start();
		sdaOe = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sdaOe = 1'b1;
		hold();
		scl = 1'b0;
		hold();
	endtask : start
	task automatic stop();
		sdaOe = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sdaOe = 1'b0;
		hold();
	endtask : stop
	// eight bits out or in, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(last, r);
	endtask : xfer
endmodule : omd_host
`default_nettype wire

// ---- dv/omd_diag_regs_tb_top.sv ----
// self-checking bench for the diagnostic byte bank
`timescale 1ns/100ps
`default_nettype none
module omd_diag_regs_tb_top
	import omd_pkg::*;
;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic measStrobe = 1'b0;
	logic [15:0] cur [5] = '{default: 16'h0000};
	logic [15:0] old [5];
	logic [5:0] pins = 6'h00;
	logic scl, hostOe, dutOe, sdaOut, sdaLine, r;
	logic laserOff, powerDownMode, moduleReset;
	logic [15:0] lf = 16'h0011;
	logic [7:0] q;
	logic softPd = 1'b0;
	logic softTx = 1'b0;
	logic notReady = 1'b1;
	int n_errors = 0;
	int cmp_count = 0;
	int rstSeen = 0;
	assign sdaLine = ~(hostOe | dutOe);
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (moduleReset === 1'b1)
			rstSeen++;
	omd_host omd_host_inst (.core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaOe(hostOe));
	omd_diag_regs omd_diag_regs_inst (
		.core_clk(core_clk), .reset_n(reset_n), .mgmtScl(scl), .mgmtSdaIn(sdaLine),
		.mgmtSdaOut(sdaOut), .mgmtSdaOe(dutOe), .biasMeas(cur[0]), .txPowerMeas(cur[1]),
		.rxPowerMeas(cur[2]), .auxOneMeas(cur[3]), .auxTwoMeas(cur[4]),
		.measStrobe(measStrobe), .optical_signal_lost(pins[0]), .intPinLevel(pins[1]),
		.powerDownPin(pins[2]), .module_unready_pin(pins[3]), .txDisablePin(pins[4]),
		.receive_recovery_unlocked(pins[5]), .laserOff(laserOff),
		.powerDownMode(powerDownMode), .moduleReset(moduleReset));
	function automatic logic [15:0] nextLf(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nextLf
	function automatic logic [7:0] expCtrl();
		return {pins[4], softTx, pins[3], pins[2], softPd, pins[1], pins[0], notReady};
	endfunction : expCtrl
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test();
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic setPtr(input logic [7:0] ofs);
		omd_host_inst.start();
		omd_host_inst.xfer({DEFAULT_DEV_ADDR, 1'b0}, 1'b1, q, r);
		chk(r, 1'b0);
		omd_host_inst.xfer(ofs, 1'b1, q, r);
		chk(r, 1'b0);
	endtask : setPtr
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		setPtr(ofs);
		omd_host_inst.xfer(d, 1'b1, q, r);
		chk(r, 1'b0);
		omd_host_inst.stop();
	endtask : wr
	task automatic rd(input logic [7:0] ofs);
		setPtr(ofs);
		omd_host_inst.start();
		omd_host_inst.xfer({DEFAULT_DEV_ADDR, 1'b1}, 1'b1, q, r);
		chk(r, 1'b0);
		omd_host_inst.xfer(8'hff, 1'b1, q, r);
		omd_host_inst.stop();
	endtask : rd
	task automatic setPins(input logic all);
		@(negedge core_clk);
		lf = nextLf(lf);
		pins = all ? 6'h3f : lf[5:0];
		repeat (3) @(negedge core_clk);
	endtask : setPins
	task automatic strobe();
		@(negedge core_clk);
		for (int i = 0; i < MEAS_COUNT; i++)
		begin
			old[i] = cur[i];
			lf = nextLf(lf);
			cur[i] = lf;
		end
		measStrobe = 1'b1;
		@(negedge core_clk);
		measStrobe = 1'b0;
	endtask : strobe
	initial
	begin
		repeat (6) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		chk({sdaOut, laserOff, powerDownMode}, 3'h0);
		for (int k = 0; k < 4; k++)
		begin
			setPins(k == 0);
			rd(OFS_CTRL);
			chk(q, expCtrl());
			rd(OFS_LOCK);
			chk(q, {4'h0, pins[5], 3'h0});
		end
		strobe();
		notReady = 1'b0;
		for (int p = 0; p < MEAS_COUNT; p++)
		begin
			rd(8'(OFS_BIAS_HI + 2 * p));
			chk(q, cur[p][15:8]);
			strobe();
			rd(8'(OFS_BIAS_LO + 2 * p));
			chk(q, old[p][7:0]);
		end
		rd(OFS_CTRL);
		chk(q, expCtrl());
		setPtr(OFS_RXPWR_HI);
		omd_host_inst.start();
		omd_host_inst.xfer({DEFAULT_DEV_ADDR, 1'b1}, 1'b1, q, r);
		chk(r, 1'b0);
		omd_host_inst.xfer(8'hff, 1'b0, q, r);
		chk(q, cur[2][15:8]);
		omd_host_inst.xfer(8'hff, 1'b1, q, r);
		chk(q, cur[2][7:0]);
		omd_host_inst.stop();
		wr(OFS_BIAS_HI, 8'h5a);
		rd(OFS_BIAS_HI);
		chk(q, cur[0][15:8]);
		rd(8'h70);
		chk(q, 8'h00);
		omd_host_inst.start();
		omd_host_inst.xfer({DEFAULT_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, r);
		chk(r, 1'b1);
		omd_host_inst.stop();
		@(negedge core_clk);
		pins = 6'h04;
		repeat (3) @(negedge core_clk);
		chk(powerDownMode, 1'b1);
		rstSeen = 0;
		pins = 6'h00;
		repeat (3) @(negedge core_clk);
		chk(rstSeen, 1);
		rstSeen = 0;
		for (int k = 0; k < 5; k++)
		begin
			omd_host_inst.half = (k == 2) ? 20 : 8;
			softTx = k[0] & (k < 4);
			softPd = k[1];
			wr(OFS_CTRL, 8'hb7 | {1'b0, softTx, 2'b00, softPd, 3'b000});
			@(negedge core_clk);
			pins[4] = k[1] ^ k[0];
			repeat (3) @(negedge core_clk);
			chk(laserOff, softTx | pins[4]);
			chk(powerDownMode, softPd);
			rd(OFS_CTRL);
			chk(q, expCtrl());
		end
		chk(rstSeen, 0);
		finish_test();
	end
	initial
	begin
		repeat (90000) @(posedge core_clk);
		n_errors++;
		finish_test();
	end
endmodule : omd_diag_regs_tb_top
`default_nettype wire
